// file: screg_defs.vh
`ifndef SCREG_DEFS_VH
`define SCREG_DEFS_VH
`define SCREG_OFF_BOOT        16'h1010
`define SCREG_OFF_TSEL_HI     16'h1044
`define SCREG_OFF_TOFF_LO     16'h1048
`define SCREG_OFF_TOFF_HI     16'h104c
`define SCREG_OFF_TCOMMIT     16'h1054
`define SCREG_OFF_PEXT        16'h1060
`define SCREG_OFF_PCOMMIT     16'h1074
`define SCREG_OFF_LAUNCH      16'h1400
`define SCREG_OFF_ENTRY0      16'h1404
`define SCREG_OFF_ENTRY1      16'h1408
`define SCREG_OFF_TUNNEL      16'h14a0
`define SCREG_RST_TSEL_HI     32'h11111111
`define SCREG_RST_TOFF        32'h76543210
`define SCREG_RST_PEXT        32'h55000000
`define SCREG_RST_ZERO        32'h00000000
`define SCREG_RST_LIVE_PEXT   16'hf000
`define SCREG_MASK_FULL       32'hffffffff
`define SCREG_BIT_COMMIT      0
`define SCREG_BIT_START0      0
`define SCREG_BIT_START1      1
`define SCREG_BIT_AUTO        4
`define SCREG_BIT_POL         8
`define SCREG_RNG_CORE        10:9
`define SCREG_RNG_MULTI       13:12
`define SCREG_RNG_MIRROR      1:0
`define SCREG_RNG_IMAGE       5:4
`define SCREG_BIT_NOCACHE     7
`define SCREG_RNG_TUNNEL_ARB_PRECEDENCE        1:0
`define SCREG_TUNNEL_ARB_PRECEDENCE_ILLEGAL    2'h3
`define SCREG_MASK_PEXT       32'h55555555
`define SCREG_MASK_LAUNCH     32'h00003710
`define SCREG_MASK_BOOT       32'h000000b3
`define SCREG_MASK_TUNNEL     32'h00000003
`define SCREG_RESP_OKAY       2'h0
`define SCREG_RESP_SLVERR     2'h2
`endif

// file: screg_bank.v
// Operation
// - nibble selects target, seven codes, seven reserved
// - apertures eight-fifteen selects, reset DDR
// - offset nibble relocates by n*256MB
// - offset registers reset to ascending nibbles
// - decoder settings applied on commit write
// - extension bits at even positions, 4GB
// - upper four extension bits reset set
// - extension applied on its commit write
// - start bits pulse core zero or one
// - auto start bit, strapped at reset
// - pulse polarity bit, resets high
// - boot core select, strapped
// - single or dual core, strapped
// - two entry point registers, reset zero
// - boot mirror field, strapped
// - image source field, strapped
// - cacheless emulation bit, strapped
// - tunnel arbitration precedence, three illegal
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "screg_defs.vh"
module screg_bank (
    input  wire        clk_sys,
    input  wire        arst_n,
    input  wire [15:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [15:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        strap_auto_start,
    input  wire [1:0]  strap_core_sel,
    input  wire [1:0]  strap_multi_core,
    input  wire [1:0]  strap_mirror,
    input  wire [1:0]  strap_image_origin,
    input  wire        strap_cacheless,
    output reg  [31:0] live_target_sel_hi,
    output reg  [31:0] live_offset_lo,
    output reg  [31:0] live_offset_hi,
    output reg  [15:0] live_phys_ext,
    output reg         core0_launch,
    output reg         core1_launch,
    output wire        launch_auto,
    output wire [1:0]  boot_core_sel,
    output wire [1:0]  multi_core_mode,
    output wire [1:0]  boot_mirror,
    output wire [1:0]  boot_image_origin,
    output wire        cacheless_emulation,
    output wire [1:0]  tunnel_arb_precedence,
    output wire        tunnel_tunnel_arb_precedence_illegal
);
    reg  [31:0] tsel_hi_r;
    reg  [31:0] toff_lo_r;
    reg  [31:0] toff_hi_r;
    reg  [31:0] pext_r;
    reg  [31:0] launch_r;
    reg  [31:0] entry0_r;
    reg  [31:0] entry1_r;
    reg  [31:0] boot_r;
    reg  [31:0] tunnel_r;
    reg         strap_done_r;
    reg  [15:0] awaddr_r;
    reg         aw_held_r;
    reg  [31:0] wdata_r;
    reg  [3:0]  wstrb_r;
    reg         w_held_r;
    reg         start0_r;
    reg         start1_r;
    wire        wr_go;
    wire [15:0] wr_addr;
    wire [31:0] wr_data;
    wire [3:0]  wr_strb;
    reg  [31:0] rd_val;
    reg         rd_hit;
    reg         wr_hit;

    // byte-lane write, then clear every bit the register does not implement
    function [31:0] merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0]  strb;
        input [31:0] mask;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge[i*8 +: 8] = data[i*8 +: 8];
                end
            end
            merge = merge & mask;
        end
    endfunction

    // compress even-position extension bits into a per-region vector
    function [15:0] pack_even;
        input [31:0] v;
        integer i;
        begin
            pack_even = 16'h0000;
            for (i = 0; i < 16; i = i + 1) begin
                pack_even[i] = v[2*i];
            end
        end
    endfunction

    // a command bit counts only when its byte lane is enabled
    function lane0_bit;
        input [3:0]   strb;
        input [31:0]  data;
        input integer idx;
        begin
            lane0_bit = strb[0] & data[idx];
        end
    endfunction

    // one write outstanding: both channels stall while the response waits
    assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held_r & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    wire aw_now = s_axi_awvalid & s_axi_awready;
    wire w_now  = s_axi_wvalid & s_axi_wready;
    assign wr_go   = (aw_held_r | aw_now) & (w_held_r | w_now);
    assign wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr;
    assign wr_data = w_held_r ? wdata_r : s_axi_wdata;
    assign wr_strb = w_held_r ? wstrb_r : s_axi_wstrb;

    // register word address with the byte lane bits dropped
    function [15:0] word_of;
        input [15:0] a;
        begin
            word_of = {a[15:2], 2'b00};
        end
    endfunction

    // true for every offset that holds a register of this bank
    function is_mapped;
        input [15:0] a;
        begin
            case (word_of(a))
                `SCREG_OFF_BOOT,
                `SCREG_OFF_TSEL_HI,
                `SCREG_OFF_TOFF_LO,
                `SCREG_OFF_TOFF_HI,
                `SCREG_OFF_TCOMMIT,
                `SCREG_OFF_PEXT,
                `SCREG_OFF_PCOMMIT,
                `SCREG_OFF_LAUNCH,
                `SCREG_OFF_ENTRY0,
                `SCREG_OFF_ENTRY1,
                `SCREG_OFF_TUNNEL: begin
                    is_mapped = 1'b1;
                end
                default: begin
                    is_mapped = 1'b0;
                end
            endcase
        end
    endfunction

    always @* begin
        wr_hit = is_mapped(wr_addr);
    end

    // a channel that arrives first is parked until its partner comes
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            aw_held_r    <= 1'b0;
            w_held_r     <= 1'b0;
            awaddr_r     <= 16'h0000;
            wdata_r      <= `SCREG_RST_ZERO;
            wstrb_r      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `SCREG_RESP_OKAY;
        end else begin
            if (wr_go) begin
                aw_held_r    <= 1'b0;
                w_held_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `SCREG_RESP_OKAY : `SCREG_RESP_SLVERR;
            end else begin
                if (aw_now) begin
                    aw_held_r <= 1'b1;
                    awaddr_r  <= s_axi_awaddr;
                end
                if (w_now) begin
                    w_held_r <= 1'b1;
                    wdata_r  <= s_axi_wdata;
                    wstrb_r  <= s_axi_wstrb;
                end
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
        end
    end

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tsel_hi_r          <= `SCREG_RST_TSEL_HI;
            toff_lo_r          <= `SCREG_RST_TOFF;
            toff_hi_r          <= `SCREG_RST_TOFF;
            pext_r             <= `SCREG_RST_PEXT;
            launch_r           <= (32'h1 << `SCREG_BIT_POL);
            entry0_r           <= `SCREG_RST_ZERO;
            entry1_r           <= `SCREG_RST_ZERO;
            boot_r             <= `SCREG_RST_ZERO;
            tunnel_r           <= `SCREG_RST_ZERO;
            strap_done_r       <= 1'b0;
            live_target_sel_hi <= `SCREG_RST_TSEL_HI;
            live_offset_lo     <= `SCREG_RST_TOFF;
            live_offset_hi     <= `SCREG_RST_TOFF;
            live_phys_ext      <= `SCREG_RST_LIVE_PEXT;
            start0_r           <= 1'b0;
            start1_r           <= 1'b0;
        end else begin
            start0_r <= 1'b0;
            start1_r <= 1'b0;
            if (!strap_done_r) begin
                // switch levels caught on the first edge after reset release
                strap_done_r <= 1'b1;
                launch_r[`SCREG_BIT_AUTO]  <= strap_auto_start;
                launch_r[`SCREG_RNG_CORE]  <= strap_core_sel;
                launch_r[`SCREG_RNG_MULTI] <= strap_multi_core;
                boot_r[`SCREG_RNG_MIRROR]  <= strap_mirror;
                boot_r[`SCREG_RNG_IMAGE]   <= strap_image_origin;
                boot_r[`SCREG_BIT_NOCACHE] <= strap_cacheless;
            end else if (wr_go) begin
                case (word_of(wr_addr))
                    `SCREG_OFF_TSEL_HI: begin
                        tsel_hi_r <= merge(tsel_hi_r, wr_data, wr_strb, `SCREG_MASK_FULL);
                    end
                    `SCREG_OFF_TOFF_LO: begin
                        toff_lo_r <= merge(toff_lo_r, wr_data, wr_strb, `SCREG_MASK_FULL);
                    end
                    `SCREG_OFF_TOFF_HI: begin
                        toff_hi_r <= merge(toff_hi_r, wr_data, wr_strb, `SCREG_MASK_FULL);
                    end
                    `SCREG_OFF_TCOMMIT: begin
                        // staged selects and offsets reach the decoder only here
                        if (lane0_bit(wr_strb, wr_data, `SCREG_BIT_COMMIT)) begin
                            live_target_sel_hi <= tsel_hi_r;
                            live_offset_lo     <= toff_lo_r;
                            live_offset_hi     <= toff_hi_r;
                        end
                    end
                    `SCREG_OFF_PEXT: begin
                        // odd bits are reserved and stay zero
                        pext_r <= merge(pext_r, wr_data, wr_strb, `SCREG_MASK_PEXT);
                    end
                    `SCREG_OFF_PCOMMIT: begin
                        if (lane0_bit(wr_strb, wr_data, `SCREG_BIT_COMMIT)) begin
                            live_phys_ext <= pack_even(pext_r);
                        end
                    end
                    `SCREG_OFF_LAUNCH: begin
                        // start bits are not stored; they only fire a pulse
                        launch_r <= merge(launch_r, wr_data, wr_strb, `SCREG_MASK_LAUNCH);
                        start0_r <= lane0_bit(wr_strb, wr_data, `SCREG_BIT_START0);
                        start1_r <= lane0_bit(wr_strb, wr_data, `SCREG_BIT_START1);
                    end
                    `SCREG_OFF_ENTRY0: begin
                        entry0_r <= merge(entry0_r, wr_data, wr_strb, `SCREG_MASK_FULL);
                    end
                    `SCREG_OFF_ENTRY1: begin
                        entry1_r <= merge(entry1_r, wr_data, wr_strb, `SCREG_MASK_FULL);
                    end
                    `SCREG_OFF_BOOT: begin
                        boot_r <= merge(boot_r, wr_data, wr_strb, `SCREG_MASK_BOOT);
                    end
                    `SCREG_OFF_TUNNEL: begin
                        // value 3 is kept and raised on the illegal flag
                        tunnel_r <= merge(tunnel_r, wr_data, wr_strb, `SCREG_MASK_TUNNEL);
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // start pulses drive at the programmed polarity, idle at the opposite level
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            core0_launch <= 1'b0;
        end else begin
            core0_launch <= start0_r ~^ launch_r[`SCREG_BIT_POL];
        end
    end

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            core1_launch <= 1'b0;
        end else begin
            core1_launch <= start1_r ~^ launch_r[`SCREG_BIT_POL];
        end
    end

    // strapped and programmed fields go straight out as levels
    assign launch_auto           = launch_r[`SCREG_BIT_AUTO];
    assign boot_core_sel         = launch_r[`SCREG_RNG_CORE];
    assign multi_core_mode       = launch_r[`SCREG_RNG_MULTI];
    assign boot_mirror           = boot_r[`SCREG_RNG_MIRROR];
    assign boot_image_origin     = boot_r[`SCREG_RNG_IMAGE];
    assign cacheless_emulation   = boot_r[`SCREG_BIT_NOCACHE];
    assign tunnel_arb_precedence = tunnel_r[`SCREG_RNG_TUNNEL_ARB_PRECEDENCE];
    assign tunnel_tunnel_arb_precedence_illegal   = (tunnel_r[`SCREG_RNG_TUNNEL_ARB_PRECEDENCE] == `SCREG_TUNNEL_ARB_PRECEDENCE_ILLEGAL);

    always @* begin
        rd_hit = is_mapped(s_axi_araddr);
        case (word_of(s_axi_araddr))
            `SCREG_OFF_BOOT: begin
                rd_val = boot_r;
            end
            `SCREG_OFF_TSEL_HI: begin
                rd_val = tsel_hi_r;
            end
            `SCREG_OFF_TOFF_LO: begin
                rd_val = toff_lo_r;
            end
            `SCREG_OFF_TOFF_HI: begin
                rd_val = toff_hi_r;
            end
            `SCREG_OFF_TCOMMIT: begin
                rd_val = `SCREG_RST_ZERO;
            end
            `SCREG_OFF_PEXT: begin
                rd_val = pext_r;
            end
            `SCREG_OFF_PCOMMIT: begin
                rd_val = `SCREG_RST_ZERO;
            end
            `SCREG_OFF_LAUNCH: begin
                rd_val = launch_r;
            end
            `SCREG_OFF_ENTRY0: begin
                rd_val = entry0_r;
            end
            `SCREG_OFF_ENTRY1: begin
                rd_val = entry1_r;
            end
            `SCREG_OFF_TUNNEL: begin
                rd_val = tunnel_r;
            end
            default: begin
                rd_val = `SCREG_RST_ZERO;
            end
        endcase
    end

    // read data is registered and held until the master takes it
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= `SCREG_RST_ZERO;
            s_axi_rresp  <= `SCREG_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= rd_hit ? `SCREG_RESP_OKAY : `SCREG_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // screg_bank

// file: screg_bank_asserts.sv
`timescale 1ns/1ps
module screg_bank_asserts (
    input wire        clk_sys,
    input wire        arst_n,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [31:0] live_target_sel_hi,
    input wire [15:0] live_phys_ext,
    input wire [1:0]  tunnel_arb_precedence,
    input wire        tunnel_tunnel_arb_precedence_illegal
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    property p_wblock; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    property p_arblock; s_axi_rvalid |-> !s_axi_arready; endproperty
    property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    property p_blat;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
    endproperty
    property p_dec_commit; $changed(live_target_sel_hi) |-> ##[0:1] $rose(s_axi_bvalid); endproperty
    property p_ext_commit; $changed(live_phys_ext) |-> ##[0:1] $rose(s_axi_bvalid); endproperty
    property p_illegal; tunnel_tunnel_arb_precedence_illegal == (tunnel_arb_precedence == 2'h3); endproperty
    a_bhold: assert property (p_bhold) else $error("write response not held");
    a_rhold: assert property (p_rhold) else $error("read data not held");
    a_wblock: assert property (p_wblock) else $error("write taken during response");
    a_arblock: assert property (p_arblock) else $error("read taken during response");
    a_rlat: assert property (p_rlat) else $error("read answer late");
    a_blat: assert property (p_blat) else $error("write answer late");
    a_dec_commit: assert property (p_dec_commit) else $error("decoder moved");
    a_ext_commit: assert property (p_ext_commit) else $error("extension moved");
    a_illegal: assert property (p_illegal) else $error("illegal flag wrong");
    c_wr: cover property (s_axi_bvalid && !s_axi_bready);
    c_rd: cover property (s_axi_rvalid && !s_axi_rready);
    c_tunnel_arb_precedence: cover property ($changed(tunnel_arb_precedence));
endmodule // screg_bank_asserts

bind screg_bank screg_bank_asserts u_screg_bank_asserts (.*);

// file: screg_bank_test.sv
`timescale 1ns/1ps
`include "screg_defs.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch %0t got %h exp %h", $time, g, e); end end
module screg_bank_test;
    logic        clk_sys = 1'b0, arst_n = 1'b0;
    logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, live_target_sel_hi, live_offset_lo;
    logic [31:0] live_offset_hi, seed = 32'h3d53;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b1, strap_auto_start, strap_cacheless;
    logic [1:0]  strap_core_sel, strap_multi_core, strap_mirror, strap_image_origin;
    logic [1:0]  s_axi_bresp, s_axi_rresp, boot_core_sel, multi_core_mode, boot_mirror;
    logic [1:0]  boot_image_origin, tunnel_arb_precedence;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        core0_launch, core1_launch, launch_auto, cacheless_emulation, tunnel_tunnel_arb_precedence_illegal;
    logic [15:0] live_phys_ext;
    logic [31:0] mdl [int];
    logic [31:0] l_sel = `SCREG_RST_TSEL_HI, l_lo = `SCREG_RST_TOFF, l_hi = `SCREG_RST_TOFF;
    logic [31:0] l_ext = `SCREG_RST_PEXT, r;
    logic [15:0] adr [11] = '{`SCREG_OFF_BOOT, `SCREG_OFF_TSEL_HI, `SCREG_OFF_TOFF_LO,
        `SCREG_OFF_TOFF_HI, `SCREG_OFF_TCOMMIT, `SCREG_OFF_PEXT, `SCREG_OFF_PCOMMIT,
        `SCREG_OFF_LAUNCH, `SCREG_OFF_ENTRY0, `SCREG_OFF_ENTRY1, `SCREG_OFF_TUNNEL};
    int          n_mismatch = 0, comparisons = 0, n0 = 0, n1 = 0;

    screg_bank u_screg_bank (.*);

    always #50 clk_sys = ~clk_sys;
    always @(negedge clk_sys) begin
        if (core0_launch === mdl[`SCREG_OFF_LAUNCH][8]) n0++;
        if (core1_launch === mdl[`SCREG_OFF_LAUNCH][8]) n1++;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [31:0] wmask(input logic [15:0] a);
        case (a)
            `SCREG_OFF_BOOT:                        return `SCREG_MASK_BOOT;
            `SCREG_OFF_PEXT:                        return `SCREG_MASK_PEXT;
            `SCREG_OFF_LAUNCH:                      return `SCREG_MASK_LAUNCH;
            `SCREG_OFF_TUNNEL:                      return `SCREG_MASK_TUNNEL;
            `SCREG_OFF_TCOMMIT, `SCREG_OFF_PCOMMIT: return 32'h0;
            default:                                return 32'hffffffff;
        endcase
    endfunction

    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
        logic aw, w, st;
        logic [31:0] m;
        aw = 1'b1;
        w = 1'b1;
        st = seed[3];
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= st;
        while (aw || w) begin
            @(negedge clk_sys);
            if (s_axi_awready) aw = 1'b0;
            if (s_axi_wready) w = 1'b0;
            @(posedge clk_sys);
            s_axi_awvalid <= aw;
            s_axi_wvalid <= w;
        end
        do @(negedge clk_sys); while (s_axi_bvalid !== 1'b1);
        `CHK(s_axi_bresp, mdl.exists(a) ? `SCREG_RESP_OKAY : `SCREG_RESP_SLVERR)
        @(posedge clk_sys);
        if (!st) begin
            s_axi_bready <= 1'b1;
            @(posedge clk_sys);
        end
        if (mdl.exists(a)) begin
            m = wmask(a) & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
            mdl[a] = (mdl[a] & ~m) | (d & m);
            if (a == `SCREG_OFF_TCOMMIT && s[0] && d[0]) begin
                l_sel = mdl[`SCREG_OFF_TSEL_HI];
                l_lo = mdl[`SCREG_OFF_TOFF_LO];
                l_hi = mdl[`SCREG_OFF_TOFF_HI];
            end
            if (a == `SCREG_OFF_PCOMMIT && s[0] && d[0]) l_ext = mdl[`SCREG_OFF_PEXT];
        end
    endtask

    task automatic rd(input logic [15:0] a);
        logic st;
        st = seed[5];
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= st;
        do @(negedge clk_sys); while (s_axi_arready !== 1'b1);
        @(posedge clk_sys);
        s_axi_arvalid <= 1'b0;
        do @(negedge clk_sys); while (s_axi_rvalid !== 1'b1);
        `CHK({s_axi_rresp,s_axi_rdata}, mdl.exists(a) ? {2'h0,mdl[a]} : 34'h200000000)
        @(posedge clk_sys);
        if (!st) begin
            s_axi_rready <= 1'b1;
            @(posedge clk_sys);
        end
    endtask

    task automatic chk_out();
        logic [15:0] x;
        logic [31:0] l, b, t;
        @(negedge clk_sys);
        for (int i = 0; i < 16; i++) x[i] = l_ext[2*i];
        l = mdl[`SCREG_OFF_LAUNCH];
        b = mdl[`SCREG_OFF_BOOT];
        t = mdl[`SCREG_OFF_TUNNEL];
        `CHK(live_target_sel_hi, l_sel)
        `CHK({live_offset_lo, live_offset_hi}, {l_lo, l_hi})
        `CHK(live_phys_ext, x)
        `CHK({launch_auto, boot_core_sel, multi_core_mode}, {l[4],l[10:9],l[13:12]})
        `CHK({boot_mirror, boot_image_origin}, {b[1:0], b[5:4]})
        `CHK(cacheless_emulation, b[7])
        `CHK({tunnel_arb_precedence, tunnel_tunnel_arb_precedence_illegal}, {t[1:0], t[1:0] == 2'h3})
        @(posedge clk_sys);
    endtask

    task automatic finish_test();
        if (n_mismatch == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        #2000000;
        n_mismatch++;
        finish_test();
    end

    initial begin
        r = rnd();
        {strap_auto_start, strap_cacheless, strap_core_sel, strap_multi_core} = r[5:0];
        {strap_mirror, strap_image_origin} = r[9:6];
        foreach (adr[i]) mdl[adr[i]] = 32'h0;
        mdl[`SCREG_OFF_TSEL_HI] = `SCREG_RST_TSEL_HI;
        mdl[`SCREG_OFF_TOFF_LO] = `SCREG_RST_TOFF;
        mdl[`SCREG_OFF_TOFF_HI] = `SCREG_RST_TOFF;
        mdl[`SCREG_OFF_PEXT] = `SCREG_RST_PEXT;
        mdl[`SCREG_OFF_BOOT] = {24'h0, strap_cacheless, 1'b0, strap_image_origin, 2'h0, strap_mirror};
        mdl[`SCREG_OFF_LAUNCH] = {18'h0, strap_multi_core, 1'b0, strap_core_sel, 1'b1, 3'h0,
            strap_auto_start, 4'h0};
        repeat (8) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        foreach (adr[i]) rd(adr[i]);
        chk_out();
        foreach (adr[i]) begin
            r = rnd();
            if (adr[i] == `SCREG_OFF_TUNNEL) r[0] = 1'b0;
            wr(adr[i], r, seed[7:4]);
        end
        wr(16'h1ffc, rnd(), 4'hf);
        foreach (adr[i]) rd(adr[i]);
        rd(16'h1000);
        chk_out();
        wr(`SCREG_OFF_TSEL_HI, 32'h65432107, 4'hf);
        wr(`SCREG_OFF_PEXT, 32'h00000055, 4'hf);
        wr(`SCREG_OFF_TCOMMIT, 32'h0, 4'hf);
        chk_out();
        wr(`SCREG_OFF_TCOMMIT, 32'h1, 4'h1);
        wr(`SCREG_OFF_PCOMMIT, 32'h1, 4'h1);
        chk_out();
        for (int v = 0; v < 3; v++) begin
            wr(`SCREG_OFF_TUNNEL, v, 4'h1);
            chk_out();
        end
        for (int p = 0; p < 2; p++) begin
            r = mdl[`SCREG_OFF_LAUNCH];
            wr(`SCREG_OFF_LAUNCH, {r[31:9], p[0], r[7:0]}, 4'hf);
            repeat (3) @(posedge clk_sys);
            n0 = 0;
            n1 = 0;
            wr(`SCREG_OFF_LAUNCH, mdl[`SCREG_OFF_LAUNCH] | 32'h3, 4'hf);
            repeat (6) @(posedge clk_sys);
            `CHK({n0, n1}, {32'd1, 32'd1})
        end
        finish_test();
    end
endmodule // screg_bank_test
